// file: ilc_defs.svh
`ifndef ILC_DEFS_SVH
`define ILC_DEFS_SVH
// register offsets, framer A then framer B
`define ILC_OFS_DN1_A 8'h15
`define ILC_OFS_UP2_A 8'h17
`define ILC_OFS_DN2_A 8'h18
`define ILC_OFS_SP1_A 8'h1B
`define ILC_OFS_SPL_A 8'h1D
`define ILC_OFS_DN1_B 8'hB5
`define ILC_OFS_UP2_B 8'hB7
`define ILC_OFS_DN2_B 8'hB8
`define ILC_OFS_SP1_B 8'hBB
`define ILC_OFS_SPL_B 8'hBD
// length field position in the spare length control register
`define ILC_LEN_MSB 2
`define ILC_LEN_LSB 0
// reset values
`define ILC_RST_PAT 8'h00
`define ILC_RST_LEN 3'h0
// code for the 8 or 16 bit length
`define ILC_LEN_LONG 3'h7
`endif

// file: ilc_pkg.sv
`default_nettype none
package ilc_pkg;
  typedef logic [7:0] ilc_byte_t;
  typedef logic [2:0] ilc_len_t;
  typedef logic [15:0] ilc_mask_t;
endpackage
`default_nettype wire

// file: ilc_regs.sv
// Function
// - a write to the down or spare first pattern byte restarts that detector's integration.
// - the spare length comes from bits 2..0 of the spare length control register.
// - each framer has its own spare length control register, at 1D and BD.
// - each framer's down pattern lives in two bytes, at 15/B5 and 18/B8.
// - each framer's second up pattern byte lives at 17 and B7.
// - each framer's first spare pattern byte lives at 1B and BB.
// - length codes 0..6 mean 1..7 bits, code 7 means 8 or 16 bits for down, 8 bits for spare.
`timescale 1ns/1ps
`default_nettype none
`include "ilc_defs.svh"
module ilc_regs (
  input wire logic clk, // 20 MHz device clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] addr, // control port address
  input wire logic wrStrobe, // one-cycle write strobe
  input wire logic rdStrobe, // one-cycle read strobe
  input wire ilc_pkg::ilc_byte_t wrData, // write data
  input wire logic spareLong16, // spare 16 bit mode select; spare mask is cut to FF00, so code 7 stays 8 bits
  input wire logic downLong16, // down detector in 16 bit mode when code is 7
  input wire ilc_pkg::ilc_len_t downLenA, // down length code, framer A
  input wire ilc_pkg::ilc_len_t downLenB, // down length code, framer B
  output var ilc_pkg::ilc_byte_t rdData_r, // read data, valid cycle after rdStrobe
  output var ilc_pkg::ilc_byte_t upByte2A_r, // up pattern byte 2, A
  output var ilc_pkg::ilc_byte_t upByte2B_r, // up pattern byte 2, B
  output var ilc_pkg::ilc_mask_t downPatA_r, // down pattern 16 bits, A
  output var ilc_pkg::ilc_mask_t downPatB_r, // down pattern 16 bits, B
  output var ilc_pkg::ilc_byte_t spareByte1A_r, // spare pattern byte 1, A
  output var ilc_pkg::ilc_byte_t spareByte1B_r, // spare pattern byte 1, B
  output var ilc_pkg::ilc_len_t spareLenA_r, // spare length code, A
  output var ilc_pkg::ilc_len_t spareLenB_r, // spare length code, B
  output var ilc_pkg::ilc_mask_t downMaskA_r, // compare mask for down detector, A
  output var ilc_pkg::ilc_mask_t downMaskB_r, // compare mask for down detector, B
  output var ilc_pkg::ilc_mask_t spareMaskA_r, // compare mask for spare detector, A
  output var ilc_pkg::ilc_mask_t spareMaskB_r, // compare mask for spare detector, B
  output logic downRestartA_r, // one-cycle integration restart, down A
  output logic downRestartB_r, // one-cycle integration restart, down B
  output logic spareRestartA_r, // one-cycle integration restart, spare A
  output logic spareRestartB_r // one-cycle integration restart, spare B
);
  import ilc_pkg::*;

  // first n bits from msb of the 16-bit pattern word; byte two only in 16 bit mode
  function automatic ilc_mask_t lenMask(input ilc_len_t code, input logic long16);
    ilc_mask_t m;
    m = 16'h0000;
    if (code == `ILC_LEN_LONG) begin
      m = long16 ? 16'hFFFF : 16'hFF00;
    end else begin
      m = ~(16'hFFFF >> ({1'b0, code} + 4'h1));
    end
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return wrStrobe && (a == ofs);
  endfunction

  // pattern byte storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upByte2A_r <= `ILC_RST_PAT;
      upByte2B_r <= `ILC_RST_PAT;
      downPatA_r <= {`ILC_RST_PAT, `ILC_RST_PAT};
      downPatB_r <= {`ILC_RST_PAT, `ILC_RST_PAT};
      spareByte1A_r <= `ILC_RST_PAT;
      spareByte1B_r <= `ILC_RST_PAT;
    end else begin
      if (hit(addr, `ILC_OFS_UP2_A)) upByte2A_r <= wrData;
      if (hit(addr, `ILC_OFS_UP2_B)) upByte2B_r <= wrData;
      if (hit(addr, `ILC_OFS_DN1_A)) downPatA_r[15:8] <= wrData;
      if (hit(addr, `ILC_OFS_DN2_A)) downPatA_r[7:0] <= wrData;
      if (hit(addr, `ILC_OFS_DN1_B)) downPatB_r[15:8] <= wrData;
      if (hit(addr, `ILC_OFS_DN2_B)) downPatB_r[7:0] <= wrData;
      if (hit(addr, `ILC_OFS_SP1_A)) spareByte1A_r <= wrData;
      if (hit(addr, `ILC_OFS_SP1_B)) spareByte1B_r <= wrData;
    end
  end

  // spare length control; upper bits are expected zero and are not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spareLenA_r <= `ILC_RST_LEN;
      spareLenB_r <= `ILC_RST_LEN;
    end else begin
      if (hit(addr, `ILC_OFS_SPL_A)) spareLenA_r <= wrData[`ILC_LEN_MSB:`ILC_LEN_LSB];
      if (hit(addr, `ILC_OFS_SPL_B)) spareLenB_r <= wrData[`ILC_LEN_MSB:`ILC_LEN_LSB];
    end
  end

  // integration restart pulses on first-byte writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      downRestartA_r <= 1'b0;
      downRestartB_r <= 1'b0;
      spareRestartA_r <= 1'b0;
      spareRestartB_r <= 1'b0;
    end else begin
      downRestartA_r <= hit(addr, `ILC_OFS_DN1_A);
      downRestartB_r <= hit(addr, `ILC_OFS_DN1_B);
      spareRestartA_r <= hit(addr, `ILC_OFS_SP1_A);
      spareRestartB_r <= hit(addr, `ILC_OFS_SP1_B);
    end
  end

  // compare masks from the length codes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      downMaskA_r <= 16'h0000;
      downMaskB_r <= 16'h0000;
      spareMaskA_r <= 16'h0000;
      spareMaskB_r <= 16'h0000;
    end else begin
      downMaskA_r <= lenMask(downLenA, downLong16);
      downMaskB_r <= lenMask(downLenB, downLong16);
      spareMaskA_r <= lenMask(spareLenA_r, spareLong16) & 16'hFF00;
      spareMaskB_r <= lenMask(spareLenB_r, spareLong16) & 16'hFF00;
    end
  end

  // read-back mux; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 8'h00;
    end else if (rdStrobe) begin
      case (addr)
        `ILC_OFS_UP2_A: rdData_r <= upByte2A_r;
        `ILC_OFS_UP2_B: rdData_r <= upByte2B_r;
        `ILC_OFS_DN1_A: rdData_r <= downPatA_r[15:8];
        `ILC_OFS_DN2_A: rdData_r <= downPatA_r[7:0];
        `ILC_OFS_DN1_B: rdData_r <= downPatB_r[15:8];
        `ILC_OFS_DN2_B: rdData_r <= downPatB_r[7:0];
        `ILC_OFS_SP1_A: rdData_r <= spareByte1A_r;
        `ILC_OFS_SP1_B: rdData_r <= spareByte1B_r;
        `ILC_OFS_SPL_A: rdData_r <= {5'h00, spareLenA_r};
        `ILC_OFS_SPL_B: rdData_r <= {5'h00, spareLenB_r};
        default: rdData_r <= 8'h00;
      endcase
    end
  end

  // register storage, restart and compare mask checks
  a_down_restart: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_DN1_A) |=> downRestartA_r && downPatA_r[15:8] == $past(wrData))
    else $error("down A restart missing");
  a_spare_restart: assert property (@(posedge clk) disable iff (!rst_b)
    spareRestartB_r |-> $past(wrStrobe) && $past(addr) == `ILC_OFS_SP1_B)
    else $error("spurious spare B restart");
  a_spare_len: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_SPL_A) |=> spareLenA_r == $past(wrData[2:0]))
    else $error("spare A length not taken");
  a_len_sep: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_SPL_A) |=> $stable(spareLenB_r))
    else $error("framer B length disturbed");
  a_down_byte2: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_DN2_B) |=> downPatB_r[7:0] == $past(wrData))
    else $error("down B byte 2 not stored");
  a_up_byte2: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_UP2_A) |=> upByte2A_r == $past(wrData))
    else $error("up A byte 2 not stored");
  a_spare_byte1: assert property (@(posedge clk) disable iff (!rst_b)
    (wrStrobe && addr == `ILC_OFS_SP1_A) |=> spareByte1A_r == $past(wrData))
    else $error("spare A byte 1 not stored");
  a_len_one: assert property (@(posedge clk) disable iff (!rst_b)
    (downLenA == 3'h0) |=> downMaskA_r == 16'h8000)
    else $error("1-bit mask wrong");
  a_len_long: assert property (@(posedge clk) disable iff (!rst_b)
    (downLenB == 3'h7 && !downLong16) |=> downMaskB_r == 16'hFF00)
    else $error("8-bit mask wrong");

  // write and read strobes that start the properties below
  sequence s_wr_dn1_b;
    wrStrobe && addr == `ILC_OFS_DN1_B;
  endsequence
  sequence s_wr_sp1_a;
    wrStrobe && addr == `ILC_OFS_SP1_A;
  endsequence
  sequence s_wr_spl_b;
    wrStrobe && addr == `ILC_OFS_SPL_B;
  endsequence
  sequence s_wr_up2_b;
    wrStrobe && addr == `ILC_OFS_UP2_B;
  endsequence
  sequence s_rd_spl_a;
    rdStrobe && addr == `ILC_OFS_SPL_A;
  endsequence
  // a down A first-byte write followed by a cycle without another such write
  sequence s_dn1a_single;
    (wrStrobe && addr == `ILC_OFS_DN1_A) ##1 !(wrStrobe && addr == `ILC_OFS_DN1_A);
  endsequence

  // restart pulses: set by the write, gone a cycle later, never without a cause
  a_down_restart_b: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_dn1_b |=> downRestartB_r && downPatB_r[15:8] == $past(wrData))
    else $error("down B restart missing");
  a_spare_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_sp1_a |=> spareRestartA_r && spareByte1A_r == $past(wrData))
    else $error("spare A restart missing");
  a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    s_dn1a_single |=> !downRestartA_r)
    else $error("down A restart longer than one cycle");
  a_down_cause: assert property (@(posedge clk) disable iff (!rst_b)
    downRestartA_r |-> $past(wrStrobe) && $past(addr) == `ILC_OFS_DN1_A)
    else $error("spurious down A restart");

  // spare length storage stays per framer
  a_spare_len_b: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_spl_b |=> spareLenB_r == $past(wrData[`ILC_LEN_MSB:`ILC_LEN_LSB]))
    else $error("spare B length not taken");
  a_len_sep_b: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_spl_b |=> $stable(spareLenA_r))
    else $error("framer A length disturbed");
  a_rd_len_top: assert property (@(posedge clk) disable iff (!rst_b)
    s_rd_spl_a |=> rdData_r == {5'h00, $past(spareLenA_r)})
    else $error("spare A length read back wrong");

  // pattern bytes and compare masks
  a_up_byte2_b: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_up2_b |=> upByte2B_r == $past(wrData) && $stable(upByte2A_r))
    else $error("up B byte 2 not stored");
  a_len_long16: assert property (@(posedge clk) disable iff (!rst_b)
    (downLenA == `ILC_LEN_LONG && downLong16) |=> downMaskA_r == 16'hFFFF)
    else $error("16-bit down A mask wrong");
  a_down_mask_b16: assert property (@(posedge clk) disable iff (!rst_b)
    (downLenB == `ILC_LEN_LONG && downLong16) |=> downMaskB_r == 16'hFFFF)
    else $error("16-bit down B mask wrong");
  a_spare_mask_len: assert property (@(posedge clk) disable iff (!rst_b)
    (spareLenA_r == 3'h2) |=> spareMaskA_r == 16'hE000)
    else $error("3-bit spare A mask wrong");
endmodule
`default_nettype wire

// file: ilc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ilc_regs_tb;
  import ilc_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic [7:0] addr = 8'h00;
  logic wrStrobe = 0, rdStrobe = 0, spareLong16 = 0, downLong16 = 0;
  ilc_byte_t wrData = 8'h00;
  ilc_len_t downLenA = 3'h0, downLenB = 3'h0;
  ilc_byte_t rdData_r, upByte2A_r, upByte2B_r, spareByte1A_r, spareByte1B_r;
  ilc_mask_t downPatA_r, downPatB_r, downMaskA_r, downMaskB_r, spareMaskA_r, spareMaskB_r;
  ilc_len_t spareLenA_r, spareLenB_r;
  logic downRestartA_r, downRestartB_r, spareRestartA_r, spareRestartB_r;
  int err_total = 0, n_compared = 0, seed = 32'h4981;
  int mem [256];
  bit mapped [256];
  int adr [12] = '{8'h15, 8'h17, 8'h18, 8'h1B, 8'h1D, 8'hB5, 8'hB7, 8'hB8, 8'hBB, 8'hBD,
    8'h16, 8'hBC};
  ilc_regs dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .wrData(wrData), .spareLong16(spareLong16), .downLong16(downLong16),
    .downLenA(downLenA), .downLenB(downLenB), .rdData_r(rdData_r), .upByte2A_r(upByte2A_r),
    .upByte2B_r(upByte2B_r), .downPatA_r(downPatA_r), .downPatB_r(downPatB_r),
    .spareByte1A_r(spareByte1A_r), .spareByte1B_r(spareByte1B_r), .spareLenA_r(spareLenA_r),
    .spareLenB_r(spareLenB_r), .downMaskA_r(downMaskA_r), .downMaskB_r(downMaskB_r),
    .spareMaskA_r(spareMaskA_r), .spareMaskB_r(spareMaskB_r),
    .downRestartA_r(downRestartA_r), .downRestartB_r(downRestartB_r),
    .spareRestartA_r(spareRestartA_r), .spareRestartB_r(spareRestartB_r));
  // 20 MHz clock
  always #25 clk = ~clk;
  // single comparison point
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // expected compare mask for a length code
  function automatic logic [15:0] mask_of(int code, bit long16);
    if (code == 7) return long16 ? 16'hFFFF : 16'hFF00;
    return 16'hFFFF << (15 - code);
  endfunction
  // stored registers against the model
  task automatic cmp_all();
    check("downPatA", downPatA_r, 16'({mem[8'h15][7:0], mem[8'h18][7:0]}));
    check("downPatB", downPatB_r, 16'({mem[8'hB5][7:0], mem[8'hB8][7:0]}));
    check("upByte2A", 16'(upByte2A_r), 16'(mem[8'h17]));
    check("upByte2B", 16'(upByte2B_r), 16'(mem[8'hB7]));
    check("spareByte1A", 16'(spareByte1A_r), 16'(mem[8'h1B]));
    check("spareByte1B", 16'(spareByte1B_r), 16'(mem[8'hBB]));
    check("spareLenA", 16'(spareLenA_r), 16'(mem[8'h1D] & 7));
    check("spareLenB", 16'(spareLenB_r), 16'(mem[8'hBD] & 7));
  endtask
  // one write cycle, restart pulses looked at in the answer cycle
  task automatic wr(int a, int d);
    @(posedge clk);
    #1;
    addr = 8'(a);
    wrData = 8'(d);
    wrStrobe = 1;
    @(posedge clk);
    #1;
    wrStrobe = 0;
    if (mapped[a]) mem[a] = d & 8'hFF;
    check("restart", 16'({downRestartA_r, downRestartB_r, spareRestartA_r, spareRestartB_r}),
      16'({a == 8'h15, a == 8'hB5, a == 8'h1B, a == 8'hBB}));
  endtask
  // one read cycle
  task automatic rd(int a);
    @(posedge clk);
    #1;
    addr = 8'(a);
    rdStrobe = 1;
    @(posedge clk);
    #1;
    rdStrobe = 0;
    check("rdData", 16'(rdData_r), 16'(mapped[a] ? mem[a] : 0));
  endtask
  // watchdog
  initial begin
    #(5000 * 50);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial begin
    int d;
    for (int i = 0; i < 10; i++) mapped[adr[i]] = 1;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1;
    cmp_all();
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 12; i++) begin
        d = $random(seed);
        if (adr[i] == 8'h1D || adr[i] == 8'hBD) d = d & 7;
        wr(adr[i], d & 8'hFF);
        cmp_all();
        rd(adr[i]);
      end
    end
    // every length code, both long modes
    for (int c = 0; c < 16; c++) begin
      downLenA = 3'(c);
      downLenB = 3'(7 - c);
      downLong16 = c[3];
      spareLong16 = c[3];
      wr(8'h1D, c & 7);
      wr(8'hBD, 7 - (c & 7));
      repeat (2) @(posedge clk);
      #1;
      check("downMaskA", downMaskA_r, mask_of(c & 7, c[3]));
      check("downMaskB", downMaskB_r, mask_of(7 - (c & 7), c[3]));
      check("spareMaskA", spareMaskA_r, mask_of(c & 7, 0));
      check("spareMaskB", spareMaskB_r, mask_of(7 - (c & 7), 0));
      cmp_all();
    end
    // mid-run reset clears every stored byte; writes work again afterwards
    rst_b = 0;
    foreach (mem[k]) mem[k] = 0;
    @(posedge clk);
    #1;
    cmp_all();
    rst_b = 1;
    wr(8'h15, 8'hA5);
    cmp_all();
    end_of_test();
  end
endmodule
`default_nettype wire
